// ==== hdl/dtc_consts.vh ====
// constants and register map of the dual timer/counter block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
// register indices; byte address is four times the index
`define DTC_IDX_CTRL    10'h088
`define DTC_IDX_MODE    10'h089
`define DTC_IDX_LOW0    10'h08A
`define DTC_IDX_LOW1    10'h08B
`define DTC_IDX_HIGH0   10'h08C
`define DTC_IDX_HIGH1   10'h08D
`define DTC_IDX_ACK     10'h08E
`define DTC_IDX_IRQEN   10'h0A8
`define DTC_RST_CTRL    8'h00
`define DTC_RST_MODE    8'h00
`define DTC_RST_BYTE    8'h00
// control register fields
`define DTC_C_TF1       7
`define DTC_C_TR1       6
`define DTC_C_TF0       5
`define DTC_C_TR0       4
`define DTC_C_IE1       3
`define DTC_C_IT1       2
`define DTC_C_IE0       1
`define DTC_C_IT0       0
// mode register fields
`define DTC_M_GATING_ONE     7
`define DTC_M_SEL1      6
`define DTC_M_GATING_ZERO     3
`define DTC_M_SEL0      2
// irq enable and service fields
`define DTC_E_GLOBAL    7
`define DTC_E_T1        3
`define DTC_E_T0        1
`define DTC_A_T0        0
`define DTC_A_T1        1
`define DTC_A_X0        2
`define DTC_A_X1        3
// peripheral cycle in timer clocks
`define DTC_PER_DIV     3'h6
`define DTC_MODE_13     2'h0
`define DTC_MODE_16     2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT  2'h3
`define DTC_RESP_OKAY   2'h0
`define DTC_RESP_SLVERR 2'h2
`endif

// ==== hdl/dtc_dual_timer.v ====
// dual timer/counter with axi4-lite register access
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_dual_timer (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        count_pin_zero,
  input  wire        count_pin_one,
  input  wire        ext_irq_pin_zero,
  input  wire        ext_irq_pin_one,
  output wire        timerIrqZero,
  output wire        timerIrqOne,
  output wire        extIrqZero,
  output wire        extIrqOne
);

  // ****************************************
  // step function shared by both timers
  // ****************************************
  // returns {overflow, high, low} after one increment
  function [16:0] dtcStep;
    input [1:0] m;
    input [7:0] th;
    input [7:0] tl;
    reg   [4:0] pre;
    begin
      pre = tl[4:0] + 5'h01;
      case (m)
        `DTC_MODE_13: begin
          // upper three low bits just hold their value
          if (tl[4:0] == 5'h1F) begin
            dtcStep = {(th == 8'hFF), th + 8'h01, tl[7:5], pre};
          end else begin
            dtcStep = {1'b0, th, tl[7:5], pre};
          end
        end
        `DTC_MODE_16: begin
          dtcStep = {1'b0, th, tl} + 17'h0_0001;
        end
        `DTC_MODE_RELOAD: begin
          if (tl == 8'hFF) begin
            dtcStep = {1'b1, th, th};
          end else begin
            dtcStep = {1'b0, th, tl + 8'h01};
          end
        end
        default: begin
          dtcStep = {1'b0, th, tl};
        end
      endcase
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] ctrl_q;
  reg  [7:0] ctrl_d;
  reg  [7:0] mode_q;
  reg  [7:0] irqEn_q;
  reg  [7:0] low0_q;
  reg  [7:0] low0_d;
  reg  [7:0] high0_q;
  reg  [7:0] high0_d;
  reg  [7:0] low1_q;
  reg  [7:0] low1_d;
  reg  [7:0] high1_q;
  reg  [7:0] high1_d;
  reg  [2:0] div_q;
  reg  [3:0] pinMeta_q;
  reg  [3:0] pinSync_q;
  reg  [1:0] extPrev_q;
  reg  [1:0] cntSmp_q;
  reg        bValid_q;
  reg  [1:0] bResp_q;
  reg        rValid_q;
  reg  [31:0] rData_q;
  reg  [1:0] rResp_q;

  // ****************************************
  // pin synchronisers and peripheral tick
  // ****************************************
  // order: ext pin one, ext pin zero, count one, count zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 4'hF;
      pinSync_q <= 4'hF;
      extPrev_q <= 2'h3;
      cntSmp_q  <= 2'h3;
      div_q     <= 3'h0;
    end else begin
      pinMeta_q <= {ext_irq_pin_one, ext_irq_pin_zero,
                    count_pin_one, count_pin_zero};
      pinSync_q <= pinMeta_q;
      extPrev_q <= pinSync_q[3:2];
      if (div_q == `DTC_PER_DIV - 3'h1) begin
        div_q    <= 3'h0;
        cntSmp_q <= pinSync_q[1:0];
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  wire       tick    = (div_q == `DTC_PER_DIV - 3'h1);
  // falling count pin seen across two peripheral samples
  wire [1:0] cntFall = cntSmp_q & ~pinSync_q[1:0];
  wire [1:0] extPin  = pinSync_q[3:2];
  wire [1:0] extFall = extPrev_q & ~extPin;

  // ****************************************
  // bus decode
  // ****************************************
  // a write waits for both channels and for the old
  // response to be taken; no skid buffer is kept
  wire       wrGo  = s_axi_awvalid & s_axi_wvalid & ~bValid_q;
  wire       wrB0  = wrGo & s_axi_wstrb[0];
  wire [9:0] wIdx  = s_axi_awaddr[11:2];
  wire [7:0] wByte = s_axi_wdata[7:0];
  wire       wCtrl = wrB0 && wIdx == `DTC_IDX_CTRL;
  wire       wMode = wrB0 && wIdx == `DTC_IDX_MODE;
  wire       wLow0 = wrB0 && wIdx == `DTC_IDX_LOW0;
  wire       wLow1 = wrB0 && wIdx == `DTC_IDX_LOW1;
  wire       wHi0  = wrB0 && wIdx == `DTC_IDX_HIGH0;
  wire       wHi1  = wrB0 && wIdx == `DTC_IDX_HIGH1;
  wire       wAck  = wrB0 && wIdx == `DTC_IDX_ACK;
  wire       wEn   = wrB0 && wIdx == `DTC_IDX_IRQEN;
  wire [3:0] ack   = wAck ? wByte[3:0] : 4'h0;

  function mapped;
    input [9:0] idx;
    begin
      mapped = (idx >= `DTC_IDX_CTRL && idx <= `DTC_IDX_ACK) ||
               idx == `DTC_IDX_IRQEN;
    end
  endfunction

  // ****************************************
  // timer zero
  // ****************************************
  wire [1:0] m0    = mode_q[1:0];
  wire [1:0] m1    = mode_q[5:4];
  wire       split = (m0 == `DTC_MODE_SPLIT);
  // gating lets the ext irq pin hold the count
  wire run0 = ctrl_q[`DTC_C_TR0] &
              (~mode_q[`DTC_M_GATING_ZERO] | extPin[0]);
  wire inc0 = tick & run0 &
              (mode_q[`DTC_M_SEL0] ? cntFall[0] : 1'b1);
  wire [16:0] step0 = dtcStep(m0, high0_q, low0_q);

  // split high byte: divided clock only, timer one's run
  wire incH  = tick & ctrl_q[`DTC_C_TR1];

  reg ovf0;
  reg ovfH;
  always @* begin
    low0_d  = low0_q;
    high0_d = high0_q;
    ovf0    = 1'b0;
    ovfH    = 1'b0;
    if (split) begin
      if (inc0) begin
        low0_d = low0_q + 8'h01;
        ovf0   = (low0_q == 8'hFF);
      end
      if (incH) begin
        high0_d = high0_q + 8'h01;
        ovfH    = (high0_q == 8'hFF);
      end
    end else if (inc0) begin
      {ovf0, high0_d, low0_d} = step0;
    end
    // software write overrides the count
    if (wLow0) begin
      low0_d = wByte;
    end
    if (wHi0) begin
      high0_d = wByte;
    end
  end

  // ****************************************
  // timer one
  // ****************************************
  // with timer zero split the run bit is taken away,
  // so timer one runs unless its gate holds it, and is stopped via mode 3
  wire run1 = (split | ctrl_q[`DTC_C_TR1]) &
              (~mode_q[`DTC_M_GATING_ONE] | extPin[1]);
  wire inc1 = tick & run1 & (m1 != `DTC_MODE_SPLIT) &
              (mode_q[`DTC_M_SEL1] ? cntFall[1] : 1'b1);
  // a halted timer one keeps its bytes for software
  wire [16:0] step1 = dtcStep(m1, high1_q, low1_q);

  reg ovf1;
  always @* begin
    low1_d  = low1_q;
    high1_d = high1_q;
    ovf1    = 1'b0;
    if (inc1) begin
      {ovf1, high1_d, low1_d} = step1;
    end
    if (wLow1) begin
      low1_d = wByte;
    end
    if (wHi1) begin
      high1_d = wByte;
    end
  end

  // ****************************************
  // control register next value
  // ****************************************
  // hardware sets are applied last, so they win over
  // a software clear or a service clear in one cycle
  wire setTf0 = ovf0;
  wire setTf1 = split ? ovfH : ovf1;
  always @* begin
    ctrl_d = ctrl_q;
    if (wCtrl) begin
      ctrl_d = wByte;
    end
    if (ack[`DTC_A_T0]) begin
      ctrl_d[`DTC_C_TF0] = 1'b0;
    end
    if (ack[`DTC_A_T1]) begin
      ctrl_d[`DTC_C_TF1] = 1'b0;
    end
    if (setTf0) begin
      ctrl_d[`DTC_C_TF0] = 1'b1;
    end
    if (setTf1) begin
      ctrl_d[`DTC_C_TF1] = 1'b1;
    end
    // level type: flag follows the low pin directly,
    // so a software write to it never takes effect
    if (!ctrl_d[`DTC_C_IT0]) begin
      ctrl_d[`DTC_C_IE0] = ~extPin[0];
    end else begin
      if (ack[`DTC_A_X0]) begin
        ctrl_d[`DTC_C_IE0] = 1'b0;
      end
      if (extFall[0]) begin
        ctrl_d[`DTC_C_IE0] = 1'b1;
      end
    end
    if (!ctrl_d[`DTC_C_IT1]) begin
      ctrl_d[`DTC_C_IE1] = ~extPin[1];
    end else begin
      if (ack[`DTC_A_X1]) begin
        ctrl_d[`DTC_C_IE1] = 1'b0;
      end
      if (extFall[1]) begin
        ctrl_d[`DTC_C_IE1] = 1'b1;
      end
    end
  end

  // ****************************************
  // state update
  // ****************************************
  // mode changes while running are not guarded;
  // software stops the timer first
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= `DTC_RST_CTRL;
      mode_q  <= `DTC_RST_MODE;
      irqEn_q <= `DTC_RST_BYTE;
      low0_q  <= `DTC_RST_BYTE;
      high0_q <= `DTC_RST_BYTE;
      low1_q  <= `DTC_RST_BYTE;
      high1_q <= `DTC_RST_BYTE;
    end else begin
      ctrl_q  <= ctrl_d;
      low0_q  <= low0_d;
      high0_q <= high0_d;
      low1_q  <= low1_d;
      high1_q <= high1_d;
      if (wMode) begin
        mode_q <= wByte;
      end
      if (wEn) begin
        irqEn_q <= wByte;
      end
    end
  end

  // ****************************************
  // interrupt request outputs
  // ****************************************
  wire glob = irqEn_q[`DTC_E_GLOBAL];
  assign timerIrqZero = ctrl_q[`DTC_C_TF0] &
                        irqEn_q[`DTC_E_T0] & glob;
  assign timerIrqOne  = ctrl_q[`DTC_C_TF1] &
                        irqEn_q[`DTC_E_T1] & glob;
  assign extIrqZero   = ctrl_q[`DTC_C_IE0];
  assign extIrqOne    = ctrl_q[`DTC_C_IE1];

  // ****************************************
  // axi4-lite response channels
  // ****************************************
  wire [9:0] rIdx = s_axi_araddr[11:2];
  reg  [7:0] rByte;
  always @* begin
    case (rIdx)
      `DTC_IDX_CTRL:  rByte = ctrl_q;
      `DTC_IDX_MODE:  rByte = mode_q;
      `DTC_IDX_LOW0:  rByte = low0_q;
      `DTC_IDX_LOW1:  rByte = low1_q;
      `DTC_IDX_HIGH0: rByte = high0_q;
      `DTC_IDX_HIGH1: rByte = high1_q;
      `DTC_IDX_IRQEN: rByte = irqEn_q;
      default:        rByte = 8'h00;
    endcase
  end

  // one read in flight: arready drops while the answer
  // waits, so rdata never changes under rvalid
  wire rdGo = s_axi_arvalid & ~rValid_q;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bValid_q <= 1'b0;
      bResp_q  <= `DTC_RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q  <= 32'h0000_0000;
      rResp_q  <= `DTC_RESP_OKAY;
    end else begin
      if (wrGo) begin
        bValid_q <= 1'b1;
        bResp_q  <= mapped(wIdx) ? `DTC_RESP_OKAY
                                 : `DTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bValid_q <= 1'b0;
      end
      if (rdGo) begin
        rValid_q <= 1'b1;
        rData_q  <= {24'h00_0000, rByte};
        rResp_q  <= mapped(rIdx) ? `DTC_RESP_OKAY
                                 : `DTC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

  // address and data are taken only together
  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = ~rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

endmodule

// ==== tb/dtc_pin_model.sv ====
// pin-side model: count pulses and gate levels
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire       ref_clk,
  input  wire       fire,
  input  wire [1:0] gateLvl,
  output logic      count_pin_zero,
  output logic      count_pin_one,
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one
);
  logic [4:0] hold_q = 5'h00;
  // each level held two peripheral cycles, so no sample misses it
  always @(posedge ref_clk) begin
    if (fire)
      hold_q <= 5'h18;
    else if (hold_q != 5'h00)
      hold_q <= hold_q - 5'h01;
  end
  // one falling edge per fire, high at rest
  assign count_pin_zero = !(hold_q > 5'h0C);
  assign count_pin_one = count_pin_zero;
  assign ext_irq_pin_zero = gateLvl[0];
  assign ext_irq_pin_one = gateLvl[1];
endmodule

// ==== tb/dtc_dual_timer_sva.sv ====
// port assertions for the dual timer block
`timescale 1ns/1ps
module dtc_dual_timer_chk (
  input wire        ref_clk,
  input wire        resetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        timerIrqZero,
  input wire        timerIrqOne
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_wrAns;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_wrAns: assert property (p_wrAns) else $error("write not answered");
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write answer dropped");
  property p_rdAns;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read answer dropped");
  property p_wTake;
    s_axi_awready |-> s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
  endproperty
  a_wTake: assert property (p_wTake) else $error("bad write take");
  property p_rByte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rByte: assert property (p_rByte) else $error("upper read bits set");
  // irq only drops through a register write
  property p_irqZero;
    $fell(timerIrqZero) |-> $rose(s_axi_bvalid);
  endproperty
  a_irqZero: assert property (p_irqZero) else $error("irq0 fell");
  property p_irqOne;
    $fell(timerIrqOne) |-> $rose(s_axi_bvalid);
  endproperty
  a_irqOne: assert property (p_irqOne) else $error("irq1 fell");
  property p_rstQuiet;
    $rose(resetn) |-> !timerIrqZero && !timerIrqOne && !s_axi_bvalid;
  endproperty
  a_rstQuiet: assert property (p_rstQuiet) else $error("busy at reset");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(timerIrqOne));
endmodule
bind dtc_dual_timer dtc_dual_timer_chk chk_u (.ref_clk, .resetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .timerIrqZero, .timerIrqOne);

// ==== tb/testbench.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`include "dtc_consts.vh"
module testbench;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, fire = 1'b0;
  logic [1:0]  gateLvl = 2'h3;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         count_pin_zero, count_pin_one;
  wire         ext_irq_pin_zero, ext_irq_pin_one;
  wire         timerIrqZero, timerIrqOne, extIrqZero, extIrqOne;
  logic [7:0]  rdVal;
  logic [1:0]  rdResp;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #5 ref_clk = ~ref_clk;
  dtc_dual_timer dut_u (.ref_clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .count_pin_zero, .count_pin_one, .ext_irq_pin_zero,
    .ext_irq_pin_one, .timerIrqZero, .timerIrqOne, .extIrqZero,
    .extIrqOne);
  dtc_pin_model pins_u (.ref_clk, .fire, .gateLvl, .count_pin_zero,
    .count_pin_one, .ext_irq_pin_zero, .ext_irq_pin_one);
  // ****
  // bus and check helpers
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge ref_clk); while (!s_axi_awready);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_bvalid);
    rdResp = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (!s_axi_arready);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_rvalid);
    rdVal = s_axi_rdata[7:0];
    rdResp = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitIrq(input int t, input int lim);
    int n;
    n = 0;
    while (!(t ? timerIrqOne : timerIrqZero) && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    check(t ? timerIrqOne : timerIrqZero, 1'b1);
  endtask
  task automatic pulse();
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (30) @(posedge ref_clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic resetVals();
    rd(`DTC_IDX_CTRL);
    check(rdVal, `DTC_RST_CTRL);
    rd(`DTC_IDX_MODE);
    check(rdVal, `DTC_RST_MODE);
    rd(10'h3FF);
    check(rdResp, `DTC_RESP_SLVERR);
    wr(10'h3FF, 8'h55);
    check(rdResp, `DTC_RESP_SLVERR);
    wr(`DTC_IDX_MODE, 8'hA5);
    rd(`DTC_IDX_MODE);
    check(rdVal, 8'hA5);
    $display("test reset done");
  endtask
  task automatic runTimer(input int t, input logic [1:0] m);
    logic [7:0] hi;
    logic [9:0] hiIdx;
    logic [9:0] loIdx;
    int c1;
    hi = (m == `DTC_MODE_RELOAD) ? 8'hFD : 8'hFF;
    hiIdx = t ? `DTC_IDX_HIGH1 : `DTC_IDX_HIGH0;
    loIdx = t ? `DTC_IDX_LOW1 : `DTC_IDX_LOW0;
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, {6'h00, m} << (4 * t));
    wr(hiIdx, hi);
    wr(loIdx, 8'hFD);
    wr(`DTC_IDX_CTRL, t ? 8'h40 : 8'h10);
    waitIrq(t, 40);
    if (m == `DTC_MODE_RELOAD) begin
      wr(`DTC_IDX_ACK, t ? 8'h02 : 8'h01);
      check(t ? timerIrqOne : timerIrqZero, 1'b0);
      waitIrq(t, 40);
      c1 = cycles;
      wr(`DTC_IDX_ACK, t ? 8'h02 : 8'h01);
      waitIrq(t, 40);
      check(cycles - c1, 6 * (256 - hi));
    end
    // stop but keep the flag, so the bytes hold still for reading
    wr(`DTC_IDX_CTRL, t ? 8'h80 : 8'h20);
    rd(hiIdx);
    check(rdVal, m == `DTC_MODE_RELOAD ? hi : 8'h00);
    rd(loIdx);
    check(rdVal, m == 2'h0 ? 8'hE0 : (m == 2'h1 ? 8'h00 : 8'hFD));
    if (m == `DTC_MODE_RELOAD) begin
      wr(`DTC_IDX_IRQEN, 8'h0A);
      rd(`DTC_IDX_CTRL);
      check(rdVal[t ? 7 : 5], 1'b1);
      check(t ? timerIrqOne : timerIrqZero, 1'b0);
      wr(`DTC_IDX_IRQEN, 8'h8A);
    end
    $display("test timer %0d mode %0d done", t, m);
  endtask
  task automatic splitMode();
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, 8'h03);
    wr(`DTC_IDX_LOW0, 8'hFD);
    wr(`DTC_IDX_HIGH0, 8'hFA);
    wr(`DTC_IDX_LOW1, 8'h10);
    wr(`DTC_IDX_CTRL, 8'h10);
    waitIrq(0, 40);
    check(timerIrqOne, 1'b0);
    wr(`DTC_IDX_CTRL, 8'h40);
    waitIrq(1, 60);
    // timer one kept off the interrupt, halted by its mode field
    wr(`DTC_IDX_MODE, 8'h33);
    wr(`DTC_IDX_LOW1, 8'h10);
    repeat (40) @(posedge ref_clk);
    rd(`DTC_IDX_LOW1);
    check(rdVal, 8'h10);
    wr(`DTC_IDX_CTRL, 8'h00);
    $display("test split done");
  endtask
  task automatic countGate();
    wr(`DTC_IDX_MODE, 8'h0E);
    wr(`DTC_IDX_HIGH0, 8'hFE);
    wr(`DTC_IDX_LOW0, 8'hFE);
    gateLvl <= 2'h2;
    wr(`DTC_IDX_CTRL, 8'h10);
    pulse();
    pulse();
    check(timerIrqZero, 1'b0);
    check(extIrqZero, 1'b1);
    check(extIrqOne, 1'b0);
    gateLvl <= 2'h3;
    pulse();
    pulse();
    check(timerIrqZero, 1'b1);
    check(extIrqZero, 1'b0);
    wr(`DTC_IDX_CTRL, 8'h01);
    gateLvl <= 2'h2;
    repeat (6) @(posedge ref_clk);
    gateLvl <= 2'h3;
    repeat (6) @(posedge ref_clk);
    check(extIrqZero, 1'b1);
    wr(`DTC_IDX_ACK, 8'h04);
    check(extIrqZero, 1'b0);
    gateLvl <= 2'h1;
    repeat (6) @(posedge ref_clk);
    check(extIrqOne, 1'b1);
    gateLvl <= 2'h3;
    repeat (6) @(posedge ref_clk);
    $display("test counter done");
  endtask
  task automatic results();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far above the several hundred cycles needed
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    resetVals();
    wr(`DTC_IDX_IRQEN, 8'h8A);
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 3; m++)
        runTimer(t, m[1:0]);
    splitMode();
    countGate();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    resetVals();
    results();
  end
endmodule
